// ===== logic/asr_pkg.sv
// Package: constants and types for the sequencer, output and system calibration registers
// ============================================================================
// Summary of operation
// - In sequencer mode 1 the converter works on the channel in the 3-bit channel select field, codes 0 to 5 only.
// - Mode field 00 is mode 1, 01 is mode 2, 10 is mode 3, and the host never writes the reserved code 11.
// - With the output switch delay enable set, output changes wait for the count in the output delay field.
// - With the channel settle delay enable set, a conversion start waits for the count in the settle delay field.
// - With ready inhibit at 1, data ready is held off during mode 2 scans until all channels are converted.
// - In modes 1 and 2 a written 1 turns an output on at once and a written 0 turns it off at once.
// - In sleep every output is off; the direct access register still takes writes but does not drive.
// - In standby with the output control source at 0, writes are taken and outputs follow at once.
// - In mode 3 with the output control source at 1, writes to the direct access register are ignored.
// - The direct access register keeps working during system offset, system gain and self calibration.
// - The system offset register is 24-bit two's complement, shifted in and out most significant bit first.
// - A system calibration never changes the user values of the offset or gain register.
// - Readback gives the user value when readback select is 1, else the internal result, valid only in conversion.
// - With offset disable at 0 the system offset is subtracted after self calibration and before gain and scaling.
// - With gain disable at 0 the offset corrected result is scaled by the unsigned 24-bit gain, up to two times.
// - While a system offset or gain calibration runs, host writes to that register are blocked.
package asr_pkg;

	// ========================================================================
	// Register addresses (serial command address field)
	localparam logic [4:0] ADDR_SEQ  = 5'h08;
	localparam logic [4:0] ADDR_GPO  = 5'h0A;
	localparam logic [4:0] ADDR_SOFF = 5'h0B;
	localparam logic [4:0] ADDR_SGAIN = 5'h0C;

	// ========================================================================
	// Reset values
	localparam logic [7:0]  RST_SEQ   = 8'h00;
	localparam logic [7:0]  RST_GPO   = 8'h00;
	localparam logic [23:0] RST_SOFF  = 24'h000000;
	localparam logic [23:0] RST_SGAIN = 24'h7FFFFF;

	// ========================================================================
	// Sequencer control field positions
	localparam int SEQ_MUX_LSB  = 5;
	localparam int SEQ_MODE_LSB = 3;
	localparam int SEQ_ODLY_BIT = 2;
	localparam int SEQ_SDLY_BIT = 1;
	localparam int SEQ_RINH_BIT = 0;
	localparam logic [2:0] CHAN_MAX = 3'h5;

	// ========================================================================
	// Serial frame layout: command byte = 0 1 a4..a0 rw
	localparam int CMD_BITS = 8;

	typedef enum logic [1:0] {
		ASR_MODE1 = 2'h0,
		ASR_MODE2 = 2'h1,
		ASR_MODE3 = 2'h2,
		ASR_MODERSV = 2'h3
	} asr_mode_t;

	typedef enum logic [1:0] {
		ASR_PWR_CONV    = 2'h0,
		ASR_PWR_STANDBY = 2'h1,
		ASR_PWR_SLEEP   = 2'h3
	} asr_pwr_t;

	function automatic logic [23:0] asr_width_mask(input logic [4:0] addr);
		asr_width_mask = (addr == ADDR_SOFF || addr == ADDR_SGAIN) ? 24'hFFFFFF : 24'h0000FF;
	endfunction

endpackage : asr_pkg

// ===== logic/asr_cal_if.sv
// Interface: correction datapath link between the register file and the corrector
`timescale 1ns/1ps
interface asr_cal_if;
	import asr_pkg::*;
	logic        [23:0] sampleIn;
	logic               sampleValid;
	logic signed [23:0] offsetVal;
	logic        [23:0] gainVal;
	logic               offsetOff;
	logic               gainOff;
	logic               unipolar;
	logic        [23:0] result;
	logic               resultValid;

	modport regs (output sampleIn, sampleValid, offsetVal, gainVal, offsetOff, gainOff, unipolar,
		input result, resultValid);
	modport corr (input sampleIn, sampleValid, offsetVal, gainVal, offsetOff, gainOff, unipolar,
		output result, resultValid);
endinterface : asr_cal_if

// ===== logic/asr_corrector.sv
// Module: system offset and gain correction of self-calibrated results
`timescale 1ns/1ps
module asr_corrector (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Datapath
	asr_cal_if.corr   cal
);
	import asr_pkg::*;

	logic signed [25:0] offCorr;
	logic signed [49:0] scaled;
	logic signed [49:0] shifted;
	logic signed [25:0] sat;

	always_comb begin
		// Offset first, then gain, then mode scaling
		offCorr = $signed({{2{cal.sampleIn[23]}}, cal.sampleIn});
		if (!cal.offsetOff)
			offCorr = offCorr - $signed({{2{cal.offsetVal[23]}}, cal.offsetVal});
		scaled = 50'(offCorr) <<< 23;
		if (!cal.gainOff)
			scaled = 50'(offCorr) * $signed({26'h0, cal.gainVal});
		shifted = scaled >>> 23;
		if (cal.unipolar)
			shifted = shifted <<< 1;
		if (shifted > 50'sh7FFFFF)
			sat = 26'sh7FFFFF;
		else if (shifted < -50'sh800000)
			sat = -26'sh800000;
		else
			sat = shifted[25:0];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cal.result      <= 24'h000000;
			cal.resultValid <= 1'b0;
		end else begin
			cal.result      <= sat[23:0];
			cal.resultValid <= cal.sampleValid;
		end
	end

endmodule // asr_corrector

// ===== logic/asr_regs.sv
// Module: sequencer, direct output and system calibration register logic behind the serial port
`timescale 1ns/1ps
module asr_regs #(
	parameter int DLY_W = 8
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// Serial port pins
	input  wire logic             sclk,
	input  wire logic             csN,
	input  wire logic             sdi,
	output logic                  sdo,
	output logic                  sdoOe,
	// Device state from the rest of the converter
	input  wire asr_pkg::asr_pwr_t pwrState,
	input  wire logic             outputControlSource,
	input  wire logic             calReadbackSelect,
	input  wire logic             systemOffsetDisable,
	input  wire logic             systemGainDisable,
	input  wire logic             unipolar,
	input  wire logic             sysOffsetCalBusy,
	input  wire logic             sysGainCalBusy,
	input  wire logic [23:0]      calOffsetResult,
	input  wire logic [23:0]      calGainResult,
	input  wire logic [DLY_W-1:0] outputDelayField,
	input  wire logic [DLY_W-1:0] settleDelayField,
	input  wire logic [1:0]       seqOutputs,
	input  wire logic             scanDone,
	// Conversion path
	input  wire logic             convRequest,
	output logic                  convStart,
	output logic [2:0]            channelSelect,
	output logic                  channelValid,
	input  wire logic [23:0]      rawSample,
	input  wire logic             rawValid,
	output logic [23:0]           corrResult,
	output logic                  corrValid,
	// Outputs
	output logic                  generalOutputZero,
	output logic                  generalOutputOne,
	output logic                  dataReadyN,
	output asr_pkg::asr_mode_t    seqMode
);
	import asr_pkg::*;

	// ========================================================================
	// Pin synchronisers
	logic [1:0] sclkSync, csSync, sdiSync;
	logic       sclkLast;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sclkSync <= 2'h0;
			csSync   <= 2'h3;
			sdiSync  <= 2'h0;
			sclkLast <= 1'b0;
		end else begin
			sclkSync <= {sclkSync[0], sclk};
			csSync   <= {csSync[0], csN};
			sdiSync  <= {sdiSync[0], sdi};
			sclkLast <= sclkSync[1];
		end
	end
	// Edges come from the second stage only; the first may be metastable
	wire sclkRise = sclkSync[1] & ~sclkLast;
	wire sclkFall = ~sclkSync[1] & sclkLast;
	wire active   = ~csSync[1];

	// ========================================================================
	// Registers
	logic [7:0]  seqReg;
	logic [7:0]  gpoReg;
	logic [23:0] soffReg;
	logic [23:0] sgainReg;

	assign seqMode       = asr_mode_t'(seqReg[SEQ_MODE_LSB +: 2]);
	assign channelSelect = seqReg[SEQ_MUX_LSB +: 3];
	// Codes 6 and 7 select no input
	assign channelValid  = (channelSelect <= CHAN_MAX);

	// ========================================================================
	// Serial frame: command byte, then data shifted MSB first
	logic [5:0]  bitCnt;
	logic [23:0] shiftIn;
	logic [23:0] shiftOut;
	logic [4:0]  addr;
	logic        isRead;
	logic        cmdOk;
	logic [5:0]  frameLen;
	logic        wrStrobe;
	logic [23:0] wrData;

	// ========================================================================
	// Command decode and readback
	// Offset and gain are the only three-byte registers
	function automatic logic isWide(input logic [4:0] a);
		return (a == ADDR_SOFF || a == ADDR_SGAIN);
	endfunction

	function automatic logic [23:0] readValue(input logic [4:0] a);
		logic [23:0] v;
		logic        intOk;
		v     = 24'h000000;
		// Internal results are only defined while converting
		intOk = (pwrState == ASR_PWR_CONV);
		unique case (a)
			ADDR_SEQ:   v = {16'h0000, seqReg};
			ADDR_GPO:   v = {16'h0000, gpoReg};
			ADDR_SOFF:  v = calReadbackSelect ? soffReg : (intOk ? calOffsetResult : 24'h000000);
			ADDR_SGAIN: v = calReadbackSelect ? sgainReg : (intOk ? calGainResult : 24'h000000);
			default:    v = 24'h000000;
		endcase
		return v;
	endfunction

	assign frameLen = isWide(addr) ? 6'h20 : 6'h10;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bitCnt   <= 6'h00;
			shiftIn  <= 24'h000000;
			shiftOut <= 24'h000000;
			addr     <= 5'h00;
			isRead   <= 1'b0;
			cmdOk    <= 1'b0;
			wrStrobe <= 1'b0;
			wrData   <= 24'h000000;
		end else begin
			wrStrobe <= 1'b0;
			if (!active) begin
				bitCnt <= 6'h00;
				// A stale read flag would release data ready during a write frame
				isRead <= 1'b0;
			end else if (sclkRise) begin
				shiftIn <= {shiftIn[22:0], sdiSync[1]};
				bitCnt  <= bitCnt + 6'd1;
				// Command byte: 0, 1, five address bits, read flag last
				if (bitCnt == 6'(CMD_BITS - 1)) begin
					addr     <= shiftIn[4:0];
					isRead   <= sdiSync[1];
					cmdOk    <= (shiftIn[6:5] == 2'h1);
					shiftOut <= readValue(shiftIn[4:0]) << (isWide(shiftIn[4:0]) ? 0 : 16);
				end
				// Write commits on the last rising edge of the frame
				if (bitCnt == frameLen - 6'd1 && !isRead && bitCnt >= 6'(CMD_BITS)) begin
					wrStrobe <= 1'b1;
					wrData   <= {shiftIn[22:0], sdiSync[1]} & asr_width_mask(addr);
				end
			// Readback moves on falling edges; the host samples at the end of each high phase, just before the falling edge
			end else if (sclkFall && bitCnt > 6'(CMD_BITS)) begin
				shiftOut <= {shiftOut[22:0], 1'b0};
			end
		end
	end

	// ========================================================================
	// Serial data out
	// Registered so the pin holds steady between bits
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sdo   <= 1'b0;
			sdoOe <= 1'b0;
		end else begin
			sdo   <= shiftOut[23];
			sdoOe <= active && isRead && cmdOk && bitCnt >= 6'(CMD_BITS);
		end
	end

	// ========================================================================
	// Register writes
	wire gpoLocked = (seqMode == ASR_MODE3) && outputControlSource;
	wire wrHit     = wrStrobe && cmdOk;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			seqReg <= RST_SEQ;
		else if (wrHit && addr == ADDR_SEQ)
			seqReg <= wrData[7:0];
	end

	// Calibration busy does not lock this one
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			gpoReg <= RST_GPO;
		else if (wrHit && addr == ADDR_GPO && !gpoLocked)
			gpoReg <= {6'h00, wrData[1:0]};
	end

	// Calibration results never land in the user copies
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			soffReg  <= RST_SOFF;
			sgainReg <= RST_SGAIN;
		end else if (wrHit) begin
			if (addr == ADDR_SOFF && !sysOffsetCalBusy)
				soffReg <= wrData;
			if (addr == ADDR_SGAIN && !sysGainCalBusy)
				sgainReg <= wrData;
		end
	end

	// ========================================================================
	// Output drive with optional switch delay
	logic [1:0]       outTarget;
	logic [1:0]       outNow;
	logic [DLY_W-1:0] outDly;

	always_comb begin
		if (pwrState == ASR_PWR_SLEEP)
			outTarget = 2'h0;
		else if (gpoLocked)
			outTarget = seqOutputs;
		else
			outTarget = gpoReg[1:0];
	end

	// Sleep bypasses the switch delay so outputs drop at once
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			outNow <= 2'h0;
			outDly <= '0;
		end else if (pwrState == ASR_PWR_SLEEP || !seqReg[SEQ_ODLY_BIT]) begin
			outNow <= outTarget;
			outDly <= '0;
		end else if (outTarget != outNow) begin
			if (outDly >= outputDelayField) begin
				outNow <= outTarget;
				outDly <= '0;
			end else
				outDly <= outDly + 1'b1;
		end else
			outDly <= '0;
	end
	assign generalOutputZero = outNow[0];
	assign generalOutputOne  = outNow[1];

	// ========================================================================
	// Conversion start with channel settle delay
	logic [DLY_W-1:0] settleCnt;
	logic             settling;

	// A zero settle count starts at once instead of wrapping
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			settleCnt <= '0;
			settling  <= 1'b0;
			convStart <= 1'b0;
		end else begin
			convStart <= 1'b0;
			if (convRequest && !settling) begin
				if (seqReg[SEQ_SDLY_BIT] && settleDelayField != '0) begin
					settling  <= 1'b1;
					settleCnt <= settleDelayField;
				end else
					convStart <= 1'b1;
			end else if (settling) begin
				settleCnt <= settleCnt - 1'b1;
				if (settleCnt == DLY_W'(1)) begin
					settling  <= 1'b0;
					convStart <= 1'b1;
				end
			end
		end
	end

	// ========================================================================
	// Correction datapath
	asr_cal_if cal ();
	assign cal.sampleIn    = rawSample;
	assign cal.sampleValid = rawValid;
	assign cal.offsetVal   = $signed(soffReg);
	assign cal.gainVal     = sgainReg;
	assign cal.offsetOff   = systemOffsetDisable;
	assign cal.gainOff     = systemGainDisable;
	assign cal.unipolar    = unipolar;

	asr_corrector uCorr (
		.clk_sys (clk_sys),
		.rst     (rst),
		.cal     (cal.corr)
	);

	// ========================================================================
	// Data ready: in mode 2 with inhibit, wait for end of scan
	logic readyN;
	wire holdReady = seqReg[SEQ_RINH_BIT] && seqMode == ASR_MODE2;

	// Any read frame counts as the host collecting the result
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			corrResult <= 24'h000000;
			corrValid  <= 1'b0;
			readyN     <= 1'b1;
		end else begin
			corrValid <= cal.resultValid;
			if (cal.resultValid)
				corrResult <= cal.result;
			if (holdReady ? scanDone : cal.resultValid)
				readyN <= 1'b0;
			else if (active && isRead)
				readyN <= 1'b1;
		end
	end
	assign dataReadyN = readyN;

endmodule // asr_regs

// ===== tb/asr_regs_assertions.sv
// Checker: concurrent assertions on the register block ports
`timescale 1ns/1ps
module asr_regs_assertions (
	// Clock, reset and serial
	input wire logic		clk_sys,
	input wire logic		rst,
	input wire logic		csN,
	input wire logic		sdoOe,
	// State and datapath
	input wire asr_pkg::asr_pwr_t	pwrState,
	input wire logic		systemOffsetDisable,
	input wire logic		systemGainDisable,
	input wire logic		unipolar,
	input wire logic		convRequest,
	input wire logic		convStart,
	input wire logic [2:0]		channelSelect,
	input wire logic		channelValid,
	input wire logic [23:0]		rawSample,
	input wire logic		rawValid,
	input wire logic [23:0]		corrResult,
	input wire logic		corrValid,
	input wire logic		generalOutputZero,
	input wire logic		generalOutputOne,
	input wire asr_pkg::asr_mode_t	seqMode
);
	import asr_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ========================================================================
	// Properties
	property p_chan; channelSelect > 3'h5 |-> !channelValid; endproperty
	a_chan: assert property (p_chan) else $error("bad channel flagged valid");
	property p_hold; csN [*8] |=> $stable(seqMode) && $stable(channelSelect); endproperty
	a_hold: assert property (p_hold) else $error("decode moved outside a frame");
	property p_sleep; (pwrState == ASR_PWR_SLEEP) [*2] |-> !generalOutputZero && !generalOutputOne; endproperty
	a_sleep: assert property (p_sleep) else $error("output on in sleep");
	property p_settle; $rose(convRequest) |-> ##[1:270] convStart; endproperty
	a_settle: assert property (p_settle) else $error("no conversion start");
	property p_pulse; convStart |=> !convStart; endproperty
	a_pulse: assert property (p_pulse) else $error("start longer than a cycle");
	property p_lat; rawValid |-> ##2 corrValid; endproperty
	a_lat: assert property (p_lat) else $error("result latency wrong");
	// Both corrections off and bipolar: the sample passes unchanged
	sequence s_raw; rawValid && systemOffsetDisable && systemGainDisable && !unipolar; endsequence
	property p_pass; s_raw ##1 (systemOffsetDisable && systemGainDisable && !unipolar) |->
		##1 corrValid && corrResult == $past(rawSample, 2); endproperty
	a_pass: assert property (p_pass) else $error("uncorrected result changed");
	property p_idle; csN [*5] |-> !sdoOe; endproperty
	a_idle: assert property (p_idle) else $error("data out driven while idle");
	c_conv: cover property (convStart);
	c_corr: cover property (corrValid && !systemOffsetDisable);
	c_sleep: cover property (pwrState == ASR_PWR_SLEEP);
endmodule // asr_regs_assertions
bind asr_regs asr_regs_assertions i_chk (.clk_sys, .rst, .csN, .sdoOe, .pwrState, .systemOffsetDisable,
	.systemGainDisable, .unipolar, .convRequest, .convStart, .channelSelect, .channelValid, .rawSample,
	.rawValid, .corrResult, .corrValid, .generalOutputZero, .generalOutputOne, .seqMode);

// ===== tb/asr_spi_host.sv
// Partner: host side of the serial port, one frame per call
`timescale 1ns/1ps
module asr_spi_host (
	// Serial pins
	output logic		sclk,
	output logic		csN,
	output logic		sdi,
	input wire logic	sdo,
	// System clock for pacing
	input wire logic	clk_sys
);
	import asr_pkg::*;
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		sdi = 1'b0;
	end
	// ========================================================================
	// Bit and frame; half period of 4 cycles, above the minimum of 2
	task automatic bitx(input logic b, output logic r);
		sdi = b;
		repeat (4) @(negedge clk_sys);
		sclk = 1'b1;
		repeat (4) @(negedge clk_sys);
		r = sdo;
		sclk = 1'b0;
	endtask
	task automatic xfer(input logic [4:0] a, input logic rw, input logic [23:0] d, output logic [23:0] q);
		logic [7:0] c;
		logic [23:0] s;
		logic r;
		int n;
		c = {2'b01, a, rw};
		n = (a == ADDR_SOFF || a == ADDR_SGAIN) ? 24 : 8;
		s = d << (24 - n);
		q = 24'h000000;
		@(negedge clk_sys);
		csN = 1'b0;
		for (int i = 7; i >= 0; i--)
			bitx(c[i], r);
		for (int i = 0; i < n; i++) begin
			bitx(s[23], r);
			s = s << 1;
			q = {q[22:0], r};
		end
		repeat (4) @(negedge clk_sys);
		csN = 1'b1;
		// Deselected line must not keep showing the last bit
		sdi = ~sdi;
		repeat (8) @(negedge clk_sys);
	endtask
endmodule // asr_spi_host

// ===== tb/tb.sv
// Testbench: register, output and correction scenarios through the serial port
`timescale 1ns/1ps
module tb;
	import asr_pkg::*;
	logic		clk_sys = 1'b0, rst = 1'b1, sclk, csN, sdi, sdo, sdoOe;
	asr_pwr_t	pwrState = ASR_PWR_CONV;
	logic		ocs = 0, crs = 1, sod = 1, sgd = 1, ob = 0, gb = 0, scanDone = 0, convRequest = 0, rawValid = 0;
	logic [23:0]	calOff = 24'hABCDEF, calGain = 24'h654321, rawSample = 24'h0, corrResult, q;
	logic [7:0]	setDly = 8'h00, odly = 8'h00;
	logic		uni = 1'b0;
	logic [1:0]	seqOutputs = 2'h0;
	logic		convStart, channelValid, corrValid, g0, g1, dataReadyN;
	logic [2:0]	channelSelect;
	asr_mode_t	seqMode;
	int		err_total = 0, compares = 0;
	always #2.5 clk_sys = ~clk_sys;
	asr_regs i_dut (.clk_sys, .rst, .sclk, .csN, .sdi, .sdo, .sdoOe, .pwrState, .outputControlSource(ocs),
		.calReadbackSelect(crs), .systemOffsetDisable(sod), .systemGainDisable(sgd), .unipolar(uni),
		.sysOffsetCalBusy(ob), .sysGainCalBusy(gb), .calOffsetResult(calOff), .calGainResult(calGain),
		.outputDelayField(odly), .settleDelayField(setDly), .seqOutputs, .scanDone, .convRequest,
		.convStart, .channelSelect, .channelValid, .rawSample, .rawValid, .corrResult, .corrValid,
		.generalOutputZero(g0), .generalOutputOne(g1), .dataReadyN, .seqMode);
	asr_spi_host i_host (.sclk, .csN, .sdi, .sdo, .clk_sys);
	// ========================================================================
	// Tasks
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		i_host.xfer(a, 1'b0, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [23:0] e);
		i_host.xfer(a, 1'b1, 24'h0, q);
		chk(q, e);
	endtask
	task automatic corr(input logic [23:0] raw, input logic [23:0] e);
		int n;
		@(negedge clk_sys);
		rawSample = raw;
		rawValid = 1;
		@(negedge clk_sys);
		rawValid = 0;
		for (n = 0; n < 20 && corrValid !== 1'b1; n++)
			@(negedge clk_sys);
		chk(corrResult, e);
	endtask
	task automatic summarize;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ========================================================================
	// Scenarios
	initial begin
		int n;
		repeat (3) @(negedge clk_sys);
		rst = 0;
		repeat (4) @(negedge clk_sys);
		chk(24'({g1, g0, dataReadyN}), 24'h1);
		rd(ADDR_SEQ, 24'h00);
		rd(ADDR_GPO, 24'h00);
		rd(ADDR_SOFF, 24'h000000);
		rd(ADDR_SGAIN, 24'h7FFFFF);
		// Reserved mode code is never written
		for (int m = 0; m < 3; m++) begin
			for (int c = 5; c < 8; c++) begin
				wr(ADDR_SEQ, 24'(c * 32 + m * 8));
				chk(24'(seqMode), 24'(m));
				chk(24'({channelSelect, channelValid}), 24'(c * 2 + (c < 6)));
			end
		end
		rd(ADDR_SEQ, 24'hF0);
		wr(ADDR_SEQ, 24'h00);
		wr(ADDR_GPO, 24'h03);
		chk(24'({g1, g0}), 24'h3);
		wr(ADDR_GPO, 24'h01);
		chk(24'({g1, g0}), 24'h1);
		odly = 8'h20;
		wr(ADDR_SEQ, 24'h04);
		wr(ADDR_GPO, 24'h03);
		chk(24'({g1, g0}), 24'h1);
		repeat (30) @(negedge clk_sys);
		chk(24'({g1, g0}), 24'h3);
		wr(ADDR_SEQ, 24'h00);
		@(negedge clk_sys) pwrState = ASR_PWR_SLEEP;
		wr(ADDR_GPO, 24'h02);
		chk(24'({g1, g0}), 24'h0);
		rd(ADDR_GPO, 24'h02);
		@(negedge clk_sys) pwrState = ASR_PWR_STANDBY;
		ob = 1;
		wr(ADDR_GPO, 24'h01);
		chk(24'({g1, g0}), 24'h1);
		ob = 0;
		ocs = 1;
		seqOutputs = 2'h2;
		wr(ADDR_SEQ, 24'h10);
		wr(ADDR_GPO, 24'h02);
		rd(ADDR_GPO, 24'h01);
		chk(24'({g1, g0}), 24'h2);
		ocs = 0;
		pwrState = ASR_PWR_CONV;
		wr(ADDR_SEQ, 24'h00);
		for (int k = 0; k < 2; k++) begin
			{gb, ob} = 2'(1 << k);
			wr(5'(ADDR_SOFF + k), 24'h123456);
			rd(5'(ADDR_SOFF + k), k ? 24'h7FFFFF : 24'h000000);
			{gb, ob} = 2'h0;
			wr(5'(ADDR_SOFF + k), 24'h800001);
			{gb, ob} = 2'(1 << k);
			rd(5'(ADDR_SOFF + k), 24'h800001);
			crs = 0;
			rd(5'(ADDR_SOFF + k), k ? calGain : calOff);
			crs = 1;
			{gb, ob} = 2'h0;
		end
		pwrState = ASR_PWR_STANDBY;
		crs = 0;
		rd(ADDR_SOFF, 24'h000000);
		crs = 1;
		pwrState = ASR_PWR_CONV;
		wr(ADDR_SOFF, 24'h000010);
		corr(24'h123456, 24'h123456);
		sod = 0;
		corr(24'h123456, 24'h123446);
		uni = 1;
		corr(24'h123456, 24'h24688C);
		uni = 0;
		wr(ADDR_SGAIN, 24'h400000);
		sgd = 0;
		corr(24'h123456, 24'h091A23);
		wr(ADDR_SGAIN, 24'h000000);
		sgd = 0;
		corr(24'h123456, 24'h000000);
		setDly = 8'h0A;
		wr(ADDR_SEQ, 24'h02);
		@(negedge clk_sys) convRequest = 1;
		@(negedge clk_sys) convRequest = 0;
		for (n = 1; n < 40 && convStart !== 1'b1; n++)
			@(negedge clk_sys);
		chk(24'(n >= 10 && n <= 13), 24'h1);
		wr(ADDR_SEQ, 24'h09);
		rd(ADDR_SEQ, 24'h09);
		corr(24'h000100, 24'h000000);
		chk(24'(dataReadyN), 24'h1);
		@(negedge clk_sys) scanDone = 1;
		@(negedge clk_sys) scanDone = 0;
		repeat (3) @(negedge clk_sys);
		chk(24'(dataReadyN), 24'h0);
		rd(ADDR_SEQ, 24'h09);
		chk(24'(dataReadyN), 24'h1);
		summarize();
	end
	initial begin
		#400000;
		err_total++;
		summarize();
	end
endmodule // tb
